// ===== shared/host_link_status_irq_consts.svh
`ifndef HOST_LINK_STATUS_IRQ_CONSTS_SVH
`define HOST_LINK_STATUS_IRQ_CONSTS_SVH

// register offsets in the i/o window
`define HOST_STATUS_OFFSET       8'h14
`define HOST_IRQ_CONTROL_OFFSET  8'h18

// status field positions
`define ST_EN_LO          0
`define ST_EV_LO          4
`define ST_SCAN_EV        6
`define ST_SUMMARY        8
`define ST_MASK_LO        9
`define ST_OUT_PENDING    16
`define ST_IN_HELD        17
`define ST_TOKEN          18
`define ST_ZERO           19
`define ST_SCAN_READY     20
`define ST_CONFIG_N       21

// control field positions
`define CT_EN_LO          0
`define CT_OUT_EMPTY_CLR  4
`define CT_IN_FULL_CLR    5
`define CT_DSP_EVENT_CLR  7
`define CT_FLAG_EN_LO     8

// reset values
`define ENABLES_RESET     4'h0
`define FLAG_EN_RESET     3'h0

`endif

// ===== shared/host_link_status_irq_pkg.sv
package host_link_status_irq_pkg;

  // latched and live event flags, in status bit order 4..7
  typedef struct packed {
    logic dsp_event;
    logic scan_ctrl_event;
    logic in_full_event;
    logic out_empty_event;
  } event_s;

  // whole block state
  typedef struct packed {
    logic [3:0]  irq_en;
    logic [2:0]  flag_host_irq_en;
    event_s      events;
    logic        out_word_pending;
    logic        in_word_held;
    logic        out_empty_prev;
    logic        dsp_req_prev;
    logic [31:0] rdata;
    logic        host_irq;
    logic [2:0]  flag_en_out;
  } state_s;

endpackage

// ===== src/host_link_status_irq.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: output-empty event latches in status bit 4 until host writes its clear.
// R2: input-full event latches in status bit 5 on each received word.
// R3: status bit 6 follows scan controller request; host writes never clear it.
// R4: dsp host interrupt sets status bit 7 until host clears it.
// R5: status bit 8 is OR of events 7..4 each gated by enables 3..0.
// R6: bit 16 sets on host write to link output, clears once sent.
// R7: bit 17 reads one while a received word is held.
// R8: bit 18 is one while board side owns the link token.
// R9: bit 20 shows scan ready pin inverted, one means ready.
// R10: bit 21 shows active-low configuration level uninverted.
// R11: bits 9..11 read back control bits 8..10.
// R12: status at 0x14 is read-only; writes ignored; bit 19 reads zero.
// R13: control at 0x18 write-only; low byte accepts status bits 7:0 back.
// R14: control bits 0..3 store the four enables, read back in status 0..3.
// R15: writing one to control bits 4, 5, 7 clears the matching flag.
// R16: control bits 8..10 enable dsp-to-host interrupts on flag lines 0..2.
// R17: gated summary drives the single interrupt request to the bridge.
// R18: host read of link input clears the held bit, allowing next word.
// R19: host writes link output only while the pending bit reads zero.
// R20: zero clear bits do nothing; a same-cycle event beats its clear.
`include "host_link_status_irq_consts.svh"

module host_link_status_irq
  import host_link_status_irq_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  io_addr_i,
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [31:0] io_wdata_i,
  output logic      [31:0] io_rdata_o,
  input  wire logic        out_word_write_i,
  input  wire logic        out_word_sent_i,
  input  wire logic        in_word_recv_i,
  input  wire logic        in_word_read_i,
  input  wire logic        token_owned_i,
  input  wire logic        scan_ctrl_irq_i,
  input  wire logic        scan_ctrl_ready_n_i,
  input  wire logic        dsp_host_irq_i,
  input  wire logic        dsp_config_n_i,
  output logic             host_irq_summary_o,
  output logic      [2:0]  flag_host_irq_en_o
);

  state_s state_reg;
  state_s state_next;

  // status word assembled from next state and live pins
  function automatic logic [31:0] status_word(input state_s s, input logic scan_irq,
                                              input logic token, input logic ready_n,
                                              input logic config_n);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ST_EN_LO +: 4]        = s.irq_en;                          // R14
    w[`ST_EV_LO]             = s.events.out_empty_event;          // R1
    w[`ST_EV_LO + 1]         = s.events.in_full_event;            // R2
    w[`ST_SCAN_EV]           = scan_irq;                          // R3
    w[`ST_EV_LO + 3]         = s.events.dsp_event;                // R4
    w[`ST_SUMMARY]           = |({s.events.dsp_event, scan_irq,
                                  s.events.in_full_event,
                                  s.events.out_empty_event} & s.irq_en); // R5
    w[`ST_MASK_LO +: 3]      = s.flag_host_irq_en;                // R11
    w[`ST_OUT_PENDING]       = s.out_word_pending;                // R6
    w[`ST_IN_HELD]           = s.in_word_held;                    // R7
    w[`ST_TOKEN]             = token;                             // R8
    w[`ST_ZERO]              = 1'b0;                              // R12
    w[`ST_SCAN_READY]        = ~ready_n;                          // R9
    w[`ST_CONFIG_N]          = config_n;                          // R10
    return w;
  endfunction

  // next-state logic; events win over same-cycle clears
  always_comb begin
    logic        ctl_wr;
    logic        empty_now;
    logic        empty_rise;
    logic        dsp_rise;
    logic [31:0] st;
    // locals start defined so no path reads a stale value
    ctl_wr     = 1'b0;
    empty_now  = 1'b0;
    empty_rise = 1'b0;
    dsp_rise   = 1'b0;
    st         = 32'h0000_0000;
    state_next = state_reg;
    ctl_wr     = io_wr_i && (io_addr_i == `HOST_IRQ_CONTROL_OFFSET); // R12 R13
    // pending bit set by host write, cleared once sent; write has priority
    if (out_word_write_i) begin
      state_next.out_word_pending = 1'b1;                         // R6 R19
    end else if (out_word_sent_i) begin
      state_next.out_word_pending = 1'b0;                         // R6
    end
    // held bit: a new word wins over a read in the same cycle
    if (in_word_recv_i) begin
      state_next.in_word_held = 1'b1;                             // R7
    end else if (in_word_read_i) begin
      state_next.in_word_held = 1'b0;                             // R18
    end
    empty_now  = ~state_next.out_word_pending;
    empty_rise = empty_now && !state_reg.out_empty_prev;
    dsp_rise   = dsp_host_irq_i && !state_reg.dsp_req_prev;
    state_next.out_empty_prev = empty_now;
    state_next.dsp_req_prev   = dsp_host_irq_i;
    // control writes: enables stored, ones in clear bits drop flags
    if (ctl_wr) begin
      state_next.irq_en           = io_wdata_i[`CT_EN_LO +: 4];       // R13 R14
      state_next.flag_host_irq_en = io_wdata_i[`CT_FLAG_EN_LO +: 3];  // R16
      if (io_wdata_i[`CT_OUT_EMPTY_CLR]) begin
        state_next.events.out_empty_event = 1'b0;                 // R15 R20
      end
      if (io_wdata_i[`CT_IN_FULL_CLR]) begin
        state_next.events.in_full_event = 1'b0;                   // R15 R20
      end
      if (io_wdata_i[`CT_DSP_EVENT_CLR]) begin
        state_next.events.dsp_event = 1'b0;                       // R15 R20
      end
    end
    // event sets placed after clears so they take priority
    if (empty_rise) begin
      state_next.events.out_empty_event = 1'b1;                   // R1 R20
    end
    if (in_word_recv_i) begin
      state_next.events.in_full_event = 1'b1;                     // R2 R20
    end
    if (dsp_rise) begin
      state_next.events.dsp_event = 1'b1;                         // R4 R20
    end
    state_next.events.scan_ctrl_event = scan_ctrl_irq_i;          // R3
    st = status_word(state_next, scan_ctrl_irq_i, token_owned_i,
                     scan_ctrl_ready_n_i, dsp_config_n_i);
    // registered read port; control register reads as zero (write-only)
    if (io_rd_i && (io_addr_i == `HOST_STATUS_OFFSET)) begin
      state_next.rdata = st;
    end else begin
      state_next.rdata = 32'h0000_0000;
    end
    state_next.host_irq    = st[`ST_SUMMARY];                     // R17
    state_next.flag_en_out = state_next.flag_host_irq_en;         // R16
  end

  // single state register; empty flag starts high so reset is no event
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg                  <= '0;
      state_reg.irq_en           <= `ENABLES_RESET;
      state_reg.flag_host_irq_en <= `FLAG_EN_RESET;
      state_reg.out_empty_prev   <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign io_rdata_o         = state_reg.rdata;
  assign host_irq_summary_o = state_reg.host_irq;
  assign flag_host_irq_en_o = state_reg.flag_en_out;

endmodule // host_link_status_irq

// ===== testbench/host_link_status_irq_asserts.sv
`timescale 1ns/100ps
module host_link_status_irq_asserts (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  io_addr_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [31:0] io_wdata_i,
  input wire logic [31:0] io_rdata_o,
  input wire logic        token_owned_i,
  input wire logic        scan_ctrl_irq_i,
  input wire logic        scan_ctrl_ready_n_i,
  input wire logic        dsp_config_n_i,
  input wire logic        host_irq_summary_o,
  input wire logic [2:0]  flag_host_irq_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // decoded host requests
  logic rd_st, wr_ct, wr_st;
  assign rd_st = io_rd_i && io_addr_i == 8'h14;
  assign wr_ct = io_wr_i && io_addr_i == 8'h18;
  assign wr_st = io_wr_i && io_addr_i == 8'h14;
  AST_RD_IDLE: assert property (!rd_st |=> io_rdata_o == 32'h0000_0000)
    else $error("read data not zero when idle");
  AST_RD_LIVE: assert property (rd_st |=> io_rdata_o[21:18] == {$past(dsp_config_n_i),
    !$past(scan_ctrl_ready_n_i), 1'b0, $past(token_owned_i)})
    else $error("live status bits wrong");
  AST_RD_SCAN: assert property (rd_st |=> io_rdata_o[6] == $past(scan_ctrl_irq_i))
    else $error("scan bit wrong");
  AST_RD_BACK: assert property (rd_st |=> io_rdata_o[11:8] ==
    {flag_host_irq_en_o, host_irq_summary_o})
    else $error("readback bits differ from outputs");
  AST_RD_HOLES: assert property (rd_st |=> io_rdata_o[31:22] == 10'h000
    && io_rdata_o[15:12] == 4'h0)
    else $error("unused status bits set");
  AST_FLAG_EN: assert property (wr_ct |=> flag_host_irq_en_o == $past(io_wdata_i[10:8]))
    else $error("flag enables not stored");
  AST_ST_WRITE: assert property (wr_st |=> $stable(flag_host_irq_en_o))
    else $error("status write had an effect");
  AST_SCAN_IRQ: assert property (wr_ct && io_wdata_i[2] && scan_ctrl_irq_i
    |=> host_irq_summary_o)
    else $error("enabled scan request gives no irq");
  AST_NO_EN: assert property (wr_ct && io_wdata_i[3:0] == 4'h0 |=> !host_irq_summary_o)
    else $error("irq without enable");
  CV_IRQ_READ: cover property (rd_st ##1 io_rdata_o[8]);
  CV_CLEAR: cover property (wr_ct && io_wdata_i[7]);
  CV_ST_WRITE: cover property (wr_st);
endmodule // host_link_status_irq_asserts
bind host_link_status_irq host_link_status_irq_asserts host_link_status_irq_asserts_i (.*);

// ===== testbench/link_peer_model.sv
`timescale 1ns/100ps
module link_peer_model (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic out_word_write_i,
  output logic      sent_o,
  output logic      recv_o
);
  int cnt = 0;
  // word leaves 1..4 cycles after the host write, like a slow handshake
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) cnt = 0;
    else if (out_word_write_i) cnt = $urandom_range(4, 1);
    else if (cnt > 0) cnt--;
    #1;
    sent_o = cnt == 1;
    recv_o = !sys_rst_i && $urandom_range(7) == 0;
  end
endmodule // link_peer_model

// ===== testbench/test_host_link_status_irq.sv
`timescale 1ns/100ps
module test_host_link_status_irq;
  logic        clk_sys_i, sys_rst_i, io_wr_i, io_rd_i, out_word_write_i, out_word_sent_i;
  logic        in_word_recv_i, in_word_read_i, token_owned_i, scan_ctrl_irq_i;
  logic        scan_ctrl_ready_n_i, dsp_host_irq_i, dsp_config_n_i, host_irq_summary_o;
  logic [7:0]  io_addr_i;
  logic [31:0] io_wdata_i, io_rdata_o, r, st, exp_rd;
  logic [2:0]  flag_host_irq_en_o, fen, ev;
  logic [3:0]  en;
  logic        pend, held, dprev, wc, oe, exp_sum;
  int          n_fail = 0, tests_run = 0;
  host_link_status_irq host_link_status_irq_i (.*);
  link_peer_model link_peer_model_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .out_word_write_i(out_word_write_i), .sent_o(out_word_sent_i), .recv_o(in_word_recv_i));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clk_sys_i = 0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // reference model, stepped on the same edge the design samples
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) {en, fen, ev, pend, held, dprev, exp_sum} = '0;
    else begin
      wc = io_wr_i && io_addr_i == 8'h18;
      oe = pend && out_word_sent_i && !out_word_write_i;
      pend = out_word_write_i || (pend && !out_word_sent_i);
      held = in_word_recv_i || (held && !in_word_read_i);
      ev[0] = oe || (ev[0] && !(wc && io_wdata_i[4]));
      ev[1] = in_word_recv_i || (ev[1] && !(wc && io_wdata_i[5]));
      ev[2] = (dsp_host_irq_i && !dprev) || (ev[2] && !(wc && io_wdata_i[7]));
      dprev = dsp_host_irq_i;
      if (wc) {fen, en} = {io_wdata_i[10:8], io_wdata_i[3:0]};
      exp_sum = |({ev[2], scan_ctrl_irq_i, ev[1:0]} & en);
      st = {10'h000, dsp_config_n_i, !scan_ctrl_ready_n_i, 1'b0, token_owned_i, held, pend,
        4'h0, fen, exp_sum, ev[2], scan_ctrl_irq_i, ev[1:0], en};
      exp_rd = (io_rd_i && io_addr_i == 8'h14) ? st : 32'h0000_0000;
      #5;
      check("io_rdata_o", exp_rd, io_rdata_o);
      check("irq outputs", {28'h0, fen, exp_sum}, {28'h0, flag_host_irq_en_o, host_irq_summary_o});
    end
  end
  // random host traffic over status, control and two unmapped offsets
  initial begin
    {io_addr_i, io_wdata_i, io_wr_i, io_rd_i, out_word_write_i, in_word_read_i} = '0;
    {token_owned_i, scan_ctrl_irq_i, scan_ctrl_ready_n_i, dsp_host_irq_i, dsp_config_n_i} = '0;
    sys_rst_i = 1;
    void'($urandom(94));
    repeat (6) @(posedge clk_sys_i);
    #1 sys_rst_i = 0;
    repeat (3000) begin
      @(posedge clk_sys_i);
      #1;
      r = $urandom;
      io_wr_i = r[1:0] == 2'b00;
      io_rd_i = !io_wr_i && r[3:2] == 2'b00;
      io_addr_i = 8'h14 + 8'(r[5:4]) * 8'h04;
      io_wdata_i = $urandom;
      out_word_write_i = !pend && r[6];
      in_word_read_i = r[7] && r[8];
      // slow levels so latched and live bits both get seen
      if (r[15:12] == 4'h0) {token_owned_i, scan_ctrl_irq_i, scan_ctrl_ready_n_i,
        dsp_host_irq_i, dsp_config_n_i} = r[20:16];
    end
    end_of_test();
  end
  initial begin
    #80000;
    n_fail++;
    end_of_test();
  end
endmodule // test_host_link_status_irq
